/* File: logic/uic_chan.sv */
`timescale 1ns/1ps
module uic_chan
	import uic_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] wdata,
	input wire logic enh_en,
	input wire logic auto_rts,
	input wire logic auto_cts,
	input wire logic rts_n,
	input wire logic cts_n,
	input wire logic [5:0] tx_count,
	input wire logic thr_empty,
	input wire logic [5:0] rx_count,
	input wire logic [5:0] rx_trig,
	input wire logic rx_char,
	input wire logic overrun,
	input wire logic err_popped,
	input wire logic [3:0] modem_change,
	input wire logic xoff_seen,
	input wire logic xon_seen,
	input wire logic special_seen,
	input wire logic sleep_exit,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	output logic [7:0] rdata,
	output logic irq,
	output logic fifo_en,
	output logic rx_ptr_reset,
	output logic tx_ptr_reset,
	output logic dma_mode,
	output logic [1:0] tx_trig_sel,
	output logic sleep_en
);
	// ****************************************
	// Internal state
	// ****************************************
	logic [7:0] interrupt_mask;
	logic [7:0] mask_eff;
	logic trig_prog;
	logic [5:0] tx_level;
	logic ls_pend, tx_pend, ms_pend, xs_pend, xs_special, fc_pend, wake;
	logic rd_level;
	logic tx_filled;
	logic [5:0] tx_prev;
	logic thr_prev, rts_prev, cts_prev;
	logic src_rd, line_rd, modem_rd, hold_rd, hold_wr, mask_wr, setup_wr;
	logic tx_set;
	logic tx_clr;
	logic xs_clr;
	logic [7:0] next_rdata;
	uic_core_if core ();

	// ****************************************
	// Register port decode
	// ****************************************
	assign src_rd = rd && addr == ADDR_SRC;
	assign line_rd = rd && addr == ADDR_LINE;
	assign modem_rd = rd && addr == ADDR_MODEM;
	assign hold_rd = rd && addr == ADDR_HOLD;
	assign hold_wr = wr && addr == ADDR_HOLD;
	assign mask_wr = wr && addr == ADDR_MASK;
	assign setup_wr = wr && addr == ADDR_SRC;

	// Upper mask bits only count with enhanced enable
	assign mask_eff = {interrupt_mask[7:4] & {4{enh_en}}, interrupt_mask[3:0]};

	// interrupt_mask storage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			interrupt_mask <= MASK_RESET;
		end else if (mask_wr) begin
			interrupt_mask <= wdata;
		end
	end

	// fifo_setup write handling
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fifo_en <= 1'b0;
			dma_mode <= 1'b0;
			tx_trig_sel <= TRIG_SEL_RESET;
			trig_prog <= 1'b0;
		end else if (setup_wr) begin
			fifo_en <= wdata[FS_EN];
			if (wdata[FS_EN]) begin
				dma_mode <= wdata[FS_DMA];
				if (enh_en) begin
					tx_trig_sel <= wdata[FS_TRIG_HI:FS_TRIG_LO];
					trig_prog <= 1'b1;
				end
			end
		end
	end

	// Pointer resets are one-cycle pulses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_ptr_reset <= 1'b0;
			tx_ptr_reset <= 1'b0;
		end else begin
			rx_ptr_reset <= setup_wr && wdata[FS_EN] && wdata[FS_RX_RST];
			tx_ptr_reset <= setup_wr && wdata[FS_EN] && wdata[FS_TX_RST];
		end
	end

	// Transmit trigger level lookup
	always_comb begin
		case (tx_trig_sel)
			2'h0: tx_level = TX_TRIG_00;
			2'h1: tx_level = TX_TRIG_01;
			2'h2: tx_level = TX_TRIG_10;
			2'h3: tx_level = TX_TRIG_11;
			default: tx_level = TX_TRIG_00;
		endcase
		if (!trig_prog) begin
			tx_level = TX_TRIG_DEFAULT;
		end
	end

	// ****************************************
	// Source detection
	// ****************************************
	// Receive data level, trigger in FIFO mode
	assign rd_level = fifo_en ? (rx_count >= rx_trig) : (rx_count != 6'h00);

	// Edge history of watched levels
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_prev <= 6'h00;
			thr_prev <= 1'b1;
			rts_prev <= 1'b1;
			cts_prev <= 1'b1;
		end else begin
			tx_prev <= tx_count;
			thr_prev <= thr_empty;
			rts_prev <= rts_n;
			cts_prev <= cts_n;
		end
	end

	// Remember whether the last reload passed the trigger
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_filled <= 1'b0;
		end else if (tx_count >= tx_level) begin
			tx_filled <= 1'b1;
		end else if (tx_count == 6'h00) begin
			tx_filled <= 1'b0;
		end
	end

	// Transmit-ready events
	always_comb begin
		tx_set = 1'b0;
		if (fifo_en) begin
			tx_set = (tx_prev >= tx_level && tx_count < tx_level)
				|| (tx_prev != 6'h00 && tx_count == 6'h00 && !tx_filled);
		end else begin
			tx_set = thr_empty && !thr_prev;
		end
		if (mask_wr && wdata[MASK_TX] && !interrupt_mask[MASK_TX] && thr_empty) begin
			tx_set = 1'b1;
		end
	end
	assign tx_clr = hold_wr || (src_rd && core.code == CODE_TX);
	assign xs_clr = src_rd && core.code == CODE_XS;

	// Transmit-ready pending, set wins over clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_pend <= 1'b0;
		end else if (tx_set) begin
			tx_pend <= 1'b1;
		end else if (tx_clr) begin
			tx_pend <= 1'b0;
		end
	end

	// Line status pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ls_pend <= 1'b0;
		end else if (overrun || err_popped) begin
			ls_pend <= 1'b1;
		end else if (line_rd) begin
			ls_pend <= 1'b0;
		end
	end

	// Modem status and flow-control pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ms_pend <= 1'b0;
			fc_pend <= 1'b0;
		end else begin
			if (|modem_change) begin
				ms_pend <= 1'b1;
			end else if (modem_rd) begin
				ms_pend <= 1'b0;
			end
			if ((auto_rts && mask_eff[MASK_RTS] && rts_n && !rts_prev)
				|| (auto_cts && mask_eff[MASK_CTS] && cts_n && !cts_prev)) begin
				fc_pend <= 1'b1;
			end else if (modem_rd) begin
				fc_pend <= 1'b0;
			end
		end
	end

	// Xoff or special character pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xs_pend <= 1'b0;
			xs_special <= 1'b0;
		end else if (xoff_seen || special_seen) begin
			xs_pend <= 1'b1;
			xs_special <= special_seen;
		end else if (xs_clr || (xon_seen && !xs_special) || (rx_char && xs_special)) begin
			xs_pend <= 1'b0;
			xs_special <= 1'b0;
		end
	end

	// Wake-up indication
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wake <= 1'b0;
		end else if (sleep_exit) begin
			wake <= 1'b1;
		end else if (src_rd) begin
			wake <= 1'b0;
		end
	end

	// ****************************************
	// Timer and priority
	// ****************************************
	assign core.bit_tick = bit_tick;
	assign core.restart = rx_char || hold_rd;
	assign core.armed = fifo_en && rx_count != 6'h00;
	assign core.char_bits = char_bits;
	assign core.pend_en[SRC_LS] = ls_pend && mask_eff[MASK_LS];
	assign core.pend_en[SRC_TO] = core.expired && mask_eff[MASK_RD];
	assign core.pend_en[SRC_RD] = rd_level && mask_eff[MASK_RD];
	assign core.pend_en[SRC_TX] = tx_pend && mask_eff[MASK_TX];
	assign core.pend_en[SRC_MS] = ms_pend && mask_eff[MASK_MS];
	assign core.pend_en[SRC_XS] = xs_pend && mask_eff[MASK_XS] && enh_en;
	assign core.pend_en[SRC_FC] = fc_pend && enh_en;

	uic_timeout u_timeout (
		.clk(clk),
		.rstn(rstn),
		.bus(core.timer)
	);

	uic_prio u_prio (
		.bus(core.prio)
	);

	// ****************************************
	// Outputs
	// ****************************************
	// Read data mux
	always_comb begin
		next_rdata = 8'h00;
		if (src_rd) begin
			next_rdata = {fifo_en, fifo_en, core.code};
		end else if (rd && addr == ADDR_MASK) begin
			next_rdata = interrupt_mask;
		end
	end

	// Registered outputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
			irq <= 1'b0;
			sleep_en <= 1'b0;
		end else begin
			rdata <= next_rdata;
			irq <= core.any;
			sleep_en <= mask_eff[MASK_SLEEP];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_irq_follows;
		@(posedge clk) disable iff (!rstn) core.any |=> irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq missing");
	property p_irq_idle;
		@(posedge clk) disable iff (!rstn) !core.any |=> !irq;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq stuck");
	property p_ls_top;
		@(posedge clk) disable iff (!rstn) src_rd && ls_pend && mask_eff[MASK_LS]
			|=> rdata[5:0] == CODE_LS;
	endproperty
	a_ls_top: assert property (p_ls_top) else $error("line status not top");
	property p_idle_code;
		@(posedge clk) disable iff (!rstn) src_rd && !core.any |=> rdata[5:0] == CODE_NONE;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle code wrong");
	property p_fifo_bits;
		@(posedge clk) disable iff (!rstn) src_rd |=> rdata[7:6] == {2{$past(fifo_en)}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits wrong");
	property p_rx_rst_pulse;
		@(posedge clk) disable iff (!rstn) rx_ptr_reset |=> !rx_ptr_reset || $past(setup_wr);
	endproperty
	a_rx_rst_pulse: assert property (p_rx_rst_pulse) else $error("rx reset stuck");
	property p_tx_rst_gate;
		@(posedge clk) disable iff (!rstn) setup_wr && !wdata[FS_EN] |=> !tx_ptr_reset && !fifo_en;
	endproperty
	a_tx_rst_gate: assert property (p_tx_rst_gate) else $error("tx reset ungated");
	property p_arm_tx;
		@(posedge clk) disable iff (!rstn)
			mask_wr && wdata[MASK_TX] && !interrupt_mask[MASK_TX] && thr_empty |=> ##1 irq;
	endproperty
	a_arm_tx: assert property (p_arm_tx) else $error("arm did not fire");
	property p_thr_clear;
		@(posedge clk) disable iff (!rstn) hold_wr && !tx_set |=> !tx_pend;
	endproperty
	a_thr_clear: assert property (p_thr_clear) else $error("tx not cleared");
	// Enhanced codes never reach the read data without the enhanced enable
	property p_enh_gate;
		@(posedge clk) disable iff (!rstn) src_rd && !enh_en |=> rdata[5:4] == 2'h0;
	endproperty
	a_enh_gate: assert property (p_enh_gate) else $error("enhanced source leaked");
	property p_line_clear;
		@(posedge clk) disable iff (!rstn) line_rd && !overrun && !err_popped |=> !ls_pend;
	endproperty
	a_line_clear: assert property (p_line_clear) else $error("line status stuck");
	c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
	c_timeout: cover property (@(posedge clk) disable iff (!rstn) $rose(core.expired));
	c_wake: cover property (@(posedge clk) disable iff (!rstn) src_rd && wake);
endmodule

/* File: logic/uic_pkg.sv */
package uic_pkg;
	// ****************************************
	// Register offsets on the channel port
	// ****************************************
	localparam logic [2:0] ADDR_HOLD = 3'h0;
	localparam logic [2:0] ADDR_MASK = 3'h1;
	localparam logic [2:0] ADDR_SRC = 3'h2;
	localparam logic [2:0] ADDR_LINE = 3'h5;
	localparam logic [2:0] ADDR_MODEM = 3'h6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [1:0] TRIG_SEL_RESET = 2'h0;

	// ****************************************
	// interrupt_mask field positions
	// ****************************************
	localparam int MASK_RD = 0;
	localparam int MASK_TX = 1;
	localparam int MASK_LS = 2;
	localparam int MASK_MS = 3;
	localparam int MASK_SLEEP = 4;
	localparam int MASK_XS = 5;
	localparam int MASK_RTS = 6;
	localparam int MASK_CTS = 7;

	// ****************************************
	// fifo_setup field positions
	// ****************************************
	localparam int FS_EN = 0;
	localparam int FS_RX_RST = 1;
	localparam int FS_TX_RST = 2;
	localparam int FS_DMA = 3;
	localparam int FS_TRIG_LO = 4;
	localparam int FS_TRIG_HI = 5;

	// ****************************************
	// Source indices, lowest index wins
	// ****************************************
	localparam int SRC_LS = 0;
	localparam int SRC_TO = 1;
	localparam int SRC_RD = 2;
	localparam int SRC_TX = 3;
	localparam int SRC_MS = 4;
	localparam int SRC_XS = 5;
	localparam int SRC_FC = 6;
	localparam int NSRC = 7;

	// ****************************************
	// interrupt_source codes, bits 5..0
	// ****************************************
	localparam logic [5:0] CODE_LS = 6'h06;
	localparam logic [5:0] CODE_TO = 6'h0C;
	localparam logic [5:0] CODE_RD = 6'h04;
	localparam logic [5:0] CODE_TX = 6'h02;
	localparam logic [5:0] CODE_MS = 6'h00;
	localparam logic [5:0] CODE_XS = 6'h10;
	localparam logic [5:0] CODE_FC = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;

	// ****************************************
	// Transmit trigger levels in characters
	// ****************************************
	localparam logic [5:0] TX_TRIG_00 = 6'h10;
	localparam logic [5:0] TX_TRIG_01 = 6'h08;
	localparam logic [5:0] TX_TRIG_10 = 6'h18;
	localparam logic [5:0] TX_TRIG_11 = 6'h1E;
	localparam logic [5:0] TX_TRIG_DEFAULT = 6'h01;

	// ****************************************
	// Receive timeout: characters plus bits
	// ****************************************
	localparam logic [6:0] TO_CHARS = 7'h04;
	localparam logic [6:0] TO_EXTRA_BITS = 7'h0C;
endpackage

/* File: logic/uic_core_if.sv */
`timescale 1ns/1ps
interface uic_core_if;
	import uic_pkg::*;
	logic [NSRC-1:0] pend_en;
	logic [5:0] code;
	logic any;
	logic bit_tick;
	logic restart;
	logic armed;
	logic [3:0] char_bits;
	logic expired;
	modport core (output pend_en, bit_tick, restart, armed, char_bits,
		input code, any, expired);
	modport prio (input pend_en, output code, any);
	modport timer (input bit_tick, restart, armed, char_bits, output expired);
endinterface

/* File: logic/uic_prio.sv */
`timescale 1ns/1ps
module uic_prio
	import uic_pkg::*;
(
	uic_core_if.prio bus
);
	// ****************************************
	// Rank enabled sources, lowest index first
	// ****************************************
	localparam logic [5:0] CODES [NSRC] = '{CODE_LS, CODE_TO, CODE_RD, CODE_TX,
		CODE_MS, CODE_XS, CODE_FC};

	// Scan from lowest priority upward so the top one lands last
	always_comb begin
		bus.code = CODE_NONE;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (bus.pend_en[i]) begin
				bus.code = CODES[i];
			end
		end
		bus.any = |bus.pend_en;
	end
endmodule

/* File: logic/uic_timeout.sv */
`timescale 1ns/1ps
module uic_timeout
	import uic_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	uic_core_if.timer bus
);
	// ****************************************
	// Idle timer in bit times
	// ****************************************
	logic [6:0] bits;
	logic [6:0] limit;

	// Four characters plus twelve bits
	assign limit = 7'(TO_CHARS * {3'h0, bus.char_bits}) + TO_EXTRA_BITS;

	// Count bit ticks while data waits in FIFO mode; restart on receive or read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bits <= 7'h00;
			bus.expired <= 1'b0;
		end else if (bus.restart || !bus.armed) begin
			bits <= 7'h00;
			bus.expired <= 1'b0;
		end else if (bus.bit_tick && !bus.expired) begin
			if (bits + 7'h01 >= limit) begin
				bus.expired <= 1'b1;
			end
			bits <= bits + 7'h01;
		end
	end
endmodule

/* File: testbench/uic_host.sv */
`timescale 1ns/1ps
// ****************************************
// Host processor on the channel register port
// ****************************************
module uic_host(
	input wire logic clk,
	output logic [2:0] addr,
	output logic rd,
	output logic wr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	// Bus idle at time zero
	initial begin
		addr = 3'h0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 8'h00;
	end

	// One write; a free edge first so strobes never retoggle in one step
	task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		addr = ~a; // Released lines carry junk
		wdata = ~d;
	endtask

	// One read; data registered at the taking edge
	task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		d = rdata;
		addr = ~a; // Released lines carry junk
	endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb
	import uic_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] addr;
	logic rd, wr_strobe, enh_en, auto_rts, auto_cts, rts_n, cts_n, thr_empty;
	logic rx_char, overrun, err_popped, xoff_seen, xon_seen, special_seen, sleep_exit;
	logic bit_tick, irq, fifo_en, rx_ptr_reset, tx_ptr_reset, dma_mode, sleep_en;
	logic [5:0] tx_count, rx_count, rx_trig;
	logic [3:0] modem_change, char_bits;
	logic [7:0] wdata, rdata, d;
	logic [1:0] tx_trig_sel;
	int errors = 0;
	int tests_run = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	uic_host u_uic_host(.clk(clk), .addr(addr), .rd(rd), .wr(wr_strobe), .wdata(wdata),
		.rdata(rdata));

	uic_chan u_uic_chan(.clk(clk), .rstn(rstn), .addr(addr), .rd(rd), .wr(wr_strobe),
		.wdata(wdata), .enh_en(enh_en), .auto_rts(auto_rts), .auto_cts(auto_cts),
		.rts_n(rts_n), .cts_n(cts_n), .tx_count(tx_count), .thr_empty(thr_empty),
		.rx_count(rx_count), .rx_trig(rx_trig), .rx_char(rx_char), .overrun(overrun),
		.err_popped(err_popped), .modem_change(modem_change), .xoff_seen(xoff_seen),
		.xon_seen(xon_seen), .special_seen(special_seen), .sleep_exit(sleep_exit),
		.bit_tick(bit_tick), .char_bits(char_bits), .rdata(rdata), .irq(irq),
		.fifo_en(fifo_en), .rx_ptr_reset(rx_ptr_reset), .tx_ptr_reset(tx_ptr_reset),
		.dma_mode(dma_mode), .tx_trig_sel(tx_trig_sel), .sleep_en(sleep_en));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Let an event reach irq, then look
	task automatic chk_irq(input logic e);
		tick(3);
		chk({7'h00, irq}, {7'h00, e});
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		u_uic_host.write_reg(a, v);
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] v;
		tick(2);
		u_uic_host.read_reg(a, v);
		chk(v, e);
	endtask

	task automatic ev(input int k, input logic v);
		case (k)
			0: overrun = v;
			1: err_popped = v;
			2: modem_change = {3'h0, v};
			3: xoff_seen = v;
			4: xon_seen = v;
			5: special_seen = v;
			6: rx_char = v;
			default: sleep_exit = v;
		endcase
	endtask

	task automatic pulse(input int k);
		ev(k, 1'b1);
		tick(1);
		ev(k, 1'b0);
		tick(3);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			bit_tick = 1'b1;
			tick(1);
			bit_tick = 1'b0;
			tick(1);
		end
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{enh_en, auto_rts, auto_cts, rts_n, cts_n, thr_empty, bit_tick} = 7'h00;
		{rx_char, overrun, err_popped, xoff_seen, xon_seen, special_seen, sleep_exit} = 7'h00;
		modem_change = 4'h0;
		char_bits = 4'hA;
		tx_count = 6'h20;
		rx_count = 6'h00;
		rx_trig = 6'h08;
		repeat (16) @(posedge clk);
		#1;
		rstn = 1'b1;
		// Reset state
		chk({fifo_en, dma_mode, tx_trig_sel, sleep_en, irq, 2'b00}, 8'h00);
		rd_chk(ADDR_MASK, MASK_RESET);
		rd_chk(ADDR_SRC, {2'b00, CODE_NONE});
		// Transmit ready without FIFOs
		thr_empty = 1'b1;
		wr(ADDR_HOLD, 8'h00);
		wr(ADDR_MASK, 8'h02);
		chk_irq(1'b1);
		thr_empty = 1'b0;
		rd_chk(ADDR_SRC, {2'b00, CODE_TX});
		chk_irq(1'b0);
		thr_empty = 1'b1;
		chk_irq(1'b1);
		wr(ADDR_HOLD, 8'h55);
		thr_empty = 1'b0;
		chk_irq(1'b0);
		wr(ADDR_MASK, 8'h00);
		// FIFO setup writes
		wr(ADDR_SRC, 8'h08);
		chk({fifo_en, dma_mode, 6'h00}, 8'h00);
		wr(ADDR_SRC, 8'h39);
		chk({fifo_en, dma_mode, tx_trig_sel, 4'h0}, 8'hC0);
		// Default trigger of one fires when the FIFO drains
		wr(ADDR_MASK, 8'h02);
		tx_count = 6'h00;
		chk_irq(1'b1);
		wr(ADDR_HOLD, 8'h00);
		wr(ADDR_MASK, 8'h00);
		tx_count = 6'h20;
		wr(ADDR_SRC, 8'h07);
		chk({fifo_en, rx_ptr_reset, tx_ptr_reset, dma_mode, 4'h0}, 8'hE0);
		tick(1);
		chk({rx_ptr_reset, tx_ptr_reset, 6'h00}, 8'h00);
		enh_en = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_SRC, {2'b00, 2'(i), 4'h1});
			chk({6'h00, tx_trig_sel}, 8'(i));
		end
		// Transmit trigger of eight characters
		wr(ADDR_SRC, 8'h11);
		tx_count = 6'h09;
		wr(ADDR_MASK, 8'h02);
		chk_irq(1'b0);
		tx_count = 6'h07;
		chk_irq(1'b1);
		rd_chk(ADDR_SRC, {2'b11, CODE_TX});
		// Priority of line, data and modem sources
		wr(ADDR_MASK, 8'h0D);
		rd_chk(ADDR_MASK, 8'h0D);
		pulse(2);
		pulse(0);
		rx_count = 6'h08;
		chk_irq(1'b1);
		rd_chk(ADDR_SRC, {2'b11, CODE_LS});
		rd_chk(ADDR_LINE, 8'h00);
		rd_chk(ADDR_SRC, {2'b11, CODE_RD});
		rx_count = 6'h07;
		rd_chk(ADDR_SRC, {2'b11, CODE_MS});
		rd_chk(ADDR_MODEM, 8'h00);
		pulse(1);
		rd_chk(ADDR_SRC, {2'b11, CODE_LS});
		rd_chk(ADDR_LINE, 8'h00);
		rd_chk(ADDR_SRC, {2'b11, CODE_NONE});
		chk_irq(1'b0);
		// Enhanced bits need the enhanced enable
		enh_en = 1'b0;
		wr(ADDR_MASK, 8'hF0);
		chk({7'h00, sleep_en}, 8'h00);
		pulse(3);
		chk_irq(1'b0);
		enh_en = 1'b1;
		wr(ADDR_MASK, 8'hF0);
		chk({7'h00, sleep_en}, 8'h01);
		pulse(3);
		rd_chk(ADDR_SRC, {2'b11, CODE_XS});
		chk_irq(1'b0);
		pulse(3);
		chk_irq(1'b1);
		pulse(4);
		chk_irq(1'b0);
		pulse(5);
		chk_irq(1'b1);
		pulse(6);
		chk_irq(1'b0);
		pulse(7);
		rd_chk(ADDR_SRC, {2'b11, CODE_NONE});
		chk_irq(1'b0);
		// Flow control pin rises
		auto_rts = 1'b1;
		auto_cts = 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (i == 0) begin
				rts_n = 1'b1;
			end else begin
				cts_n = 1'b1;
			end
			rd_chk(ADDR_SRC, {2'b11, CODE_FC});
			rd_chk(ADDR_MODEM, 8'h00);
			chk_irq(1'b0);
		end
		// Receive timeout, 4 x 10 + 12 bit times
		wr(ADDR_MASK, 8'h01);
		rx_count = 6'h02;
		pulse(6);
		ticks(51);
		chk_irq(1'b0);
		ticks(1);
		chk_irq(1'b1);
		rd_chk(ADDR_SRC, {2'b11, CODE_TO});
		u_uic_host.read_reg(ADDR_HOLD, d);
		chk_irq(1'b0);
		end_of_test();
	end
endmodule
